// ---- hdl/bus_match_read.sv ----
// read-side bus matching: long words in, long/word/byte out
// assumes memory pops on the edge where mem_pop is high and
// shows the next word after that edge
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "bus_match_defines.svh"
`default_nettype none
module bus_match_read #(
   parameter int DATA_W = `LONG_W
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic [31:0]                prdata,
   input  wire logic                  master_reset_n,
   input  wire logic                  width_match_select,
   input  wire logic                  size_select,
   input  wire logic                  msb_first_select,
   input  wire logic                  read_port_mailbox_select,
   input  wire logic                  rd_en,
   input  wire bus_match_pkg::mem_in_t mem_in,
   output logic                       mem_pop,
   output logic [35:0]                dout,
   output logic                       empty_output_ready_flag,
   output logic                       full_input_ready_flag
);

   if (DATA_W != `LONG_W) begin : g_chk
      $error("bus_match_read serves 36-bit words only");
   end

   bus_match_pkg::state_t q;
   bus_match_pkg::state_t d;
   logic                  fetch;
   logic                  take;
   logic                  mb_rd;
   logic                  big;
   logic                  access;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // lanes outside the port width driven zero
   function automatic logic [35:0] portion(
      input logic [35:0]           w,
      input bus_match_pkg::width_t wd,
      input logic                  msb
   );
      logic [35:0] r;
      r = 36'h0_0000_0000;
      case (wd)
         bus_match_pkg::W_WORD: begin
            r[17:0] = msb ? w[35:18] : w[17:0];
         end
         bus_match_pkg::W_BYTE: begin
            r[8:0] = msb ? w[35:27] : w[8:0];
         end
         default: begin
            r = w;
         end
      endcase
      return r;
   endfunction : portion

   function automatic logic [35:0] rest(
      input logic [35:0]           w,
      input bus_match_pkg::width_t wd,
      input logic                  msb
   );
      logic [35:0] r;
      r = 36'h0_0000_0000;
      case (wd)
         bus_match_pkg::W_WORD: begin
            r = msb ? (w << `WORD_W) : (w >> `WORD_W);
         end
         bus_match_pkg::W_BYTE: begin
            r = msb ? (w << `BYTE_W) : (w >> `BYTE_W);
         end
         default: begin
            r = 36'h0_0000_0000;
         end
      endcase
      return r;
   endfunction : rest

   function automatic logic [1:0] parts_after(
      input bus_match_pkg::width_t wd
   );
      logic [1:0] n;
      case (wd)
         bus_match_pkg::W_WORD: n = 2'h1;
         bus_match_pkg::W_BYTE: n = 2'h3;
         default:               n = 2'h0;
      endcase
      return n;
   endfunction : parts_after

   function automatic logic [35:0] lane_mask(
      input bus_match_pkg::width_t wd
   );
      logic [35:0] m;
      case (wd)
         bus_match_pkg::W_WORD: m = 36'h0_0003_ffff;
         bus_match_pkg::W_BYTE: m = 36'h0_0000_01ff;
         default:               m = 36'hf_ffff_ffff;
      endcase
      return m;
   endfunction : lane_mask

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      d         = q;
      d.mr      = master_reset_n;
      d.pop     = 1'b0;
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      // endian has no effect on long words
      big    = q.msb && (q.width != bus_match_pkg::W_LONG);
      mb_rd  = q.cfg_ok && rd_en && read_port_mailbox_select;
      // fetch only with nothing left aside
      fetch  = q.cfg_ok && rd_en && !read_port_mailbox_select
               && (q.left == 2'h0) && mem_in.valid && !q.pop;
      take   = q.cfg_ok && rd_en && !read_port_mailbox_select
               && (q.left != 2'h0);
      access = psel && penable && !q.pready;

      // msb-first caught on the rising edge
      if (!q.mr && master_reset_n) begin
         if (!width_match_select) begin
            d.width = bus_match_pkg::W_LONG;
         end else if (size_select) begin
            d.width = bus_match_pkg::W_BYTE;
         end else begin
            d.width = bus_match_pkg::W_WORD;
         end
         d.msb = msb_first_select;
         // settings live with the ready flag
         d.cfg_ok = 1'b1;
      end

      if (fetch) begin
         d.dout = portion(mem_in.data, q.width, big);
         d.aux  = rest(mem_in.data, q.width, big);
         d.word = mem_in.data;
         d.left = parts_after(q.width);
         d.pop  = 1'b1;
      end else if (take) begin
         d.dout = portion(q.aux, q.width, big);
         d.aux  = rest(q.aux, q.width, big);
         d.left = q.left - 2'h1;
      end else if (mb_rd) begin
         d.dout = q.mbox & lane_mask(q.width);
      end

      // flag drops only after the last portion
      d.ready = d.cfg_ok && ((d.left != 2'h0)
                || (mem_in.valid && !fetch && !q.pop));

      if (!master_reset_n) begin
         d.cfg_ok = 1'b0;
         d.left   = 2'h0;
         d.ready  = 1'b0;
      end

      // APB slave, answers in the second access cycle
      if (access) begin
         d.pready = 1'b1;
         d.prdata = `RDATA_RST;
         case (paddr)
            `CFG_OFS: begin
               d.prdata[3:0] = {q.cfg_ok, q.msb, q.width};
               d.pslverr     = pwrite;
            end
            `STAT_OFS: begin
               d.prdata[4:0] = {q.left, q.ready, q.pop,
                                mem_in.valid};
               d.pslverr     = pwrite;
            end
            `MBOX_LO_OFS: begin
               d.prdata = q.mbox[31:0];
            end
            `MBOX_HI_OFS: begin
               d.prdata[3:0] = q.mbox[35:32];
            end
            default: begin
               d.pslverr = 1'b1;
            end
         endcase
      end

      // writes land only on the completing edge of the access
      if (psel && penable && q.pready && pwrite) begin
         if (paddr == `MBOX_LO_OFS) begin
            d.mbox[31:0] = pwdata;
         end else if (paddr == `MBOX_HI_OFS) begin
            d.mbox[35:32] = pwdata[3:0];
         end
      end
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q         <= '0;
         q.width   <= bus_match_pkg::W_LONG;
         q.mbox    <= `MBOX_RST;
         q.prdata  <= `RDATA_RST;
      end else begin
         q <= d;
      end
   end

   assign pready                  = q.pready;
   assign pslverr                 = q.pslverr;
   assign prdata                  = q.prdata;
   assign mem_pop                 = q.pop;
   assign dout                    = q.dout;
   assign empty_output_ready_flag = q.ready;
   assign full_input_ready_flag   = q.cfg_ok;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_rst_rise;
      !q.mr && master_reset_n;
   endsequence

   // second byte of a long word, whatever the spacing of reads
   sequence s_byte_msb_second;
      take && q.width == bus_match_pkg::W_BYTE && q.msb
      && q.left == 2'h3;
   endsequence

   property p_width_decode;
      s_rst_rise ##0 width_match_select ##0 size_select
      |=> q.width == bus_match_pkg::W_BYTE;
   endproperty
   a_width_decode: assert property (p_width_decode)
      else $error("byte width not taken at reset rise");

   property p_cfg_ready;
      s_rst_rise |=> full_input_ready_flag ##0 q.msb ==
      $past(msb_first_select);
   endproperty
   a_cfg_ready: assert property (p_cfg_ready)
      else $error("settings not in effect with ready flag");

   property p_msb_held;
      q.cfg_ok && master_reset_n |=> $stable(q.msb);
   endproperty
   a_msb_held: assert property (p_msb_held)
      else $error("msb-first changed during operation");

   property p_long_whole;
      fetch && q.width == bus_match_pkg::W_LONG
      |=> dout == $past(mem_in.data) && q.left == 2'h0;
   endproperty
   a_long_whole: assert property (p_long_whole)
      else $error("long word not passed whole");

   property p_byte_order;
      s_byte_msb_second |=> dout[8:0] == q.word[26:18];
   endproperty
   a_byte_order: assert property (p_byte_order)
      else $error("second msb-first byte wrong");

   property p_word_lsb;
      fetch && q.width == bus_match_pkg::W_WORD && !q.msb
      |=> dout[17:0] == $past(mem_in.data[17:0]) ##0 q.left == 2'h1;
   endproperty
   a_word_lsb: assert property (p_word_lsb)
      else $error("low half not first when lsb-first");

   property p_fetch_empty;
      mem_pop |-> $past(q.left) == 2'h0;
   endproperty
   a_fetch_empty: assert property (p_fetch_empty)
      else $error("fetch while portions still held");

   property p_empty_last;
      q.cfg_ok && master_reset_n && q.left != 2'h0
      && !(take && q.left == 2'h1)
      |=> empty_output_ready_flag;
   endproperty
   a_empty_last: assert property (p_empty_last)
      else $error("empty flag low with portions left");

   property p_mbox_byte;
      mb_rd && q.width == bus_match_pkg::W_BYTE
      |=> dout == {27'h000_0000, $past(q.mbox[8:0])};
   endproperty
   a_mbox_byte: assert property (p_mbox_byte)
      else $error("mailbox byte not on low lane");

endmodule : bus_match_read
`default_nettype wire

// ---- include/bus_match_defines.svh ----
// constants for the read-side bus-matching path
// assumes one pclk domain and an APB master for registers
//
// Summary of operation
// - width from width-match and size pins
// - width applied when master reset completes
// - msb-first level caught at reset rise
// - msb-first ignored in long-word width
// - ordering applied when master reset completes
// - memory holds only whole long words
// - mailbox moves in one transfer
// - mailbox uses low lanes only
// - long word goes out whole
// - first portion out, rest held aside
// - unused output lanes driven zero
// - long-word lanes map straight through
// - word order follows msb-first select
// - byte order follows msb-first select
// - empty only after final portion read
// - mailbox ignores endian selection
`ifndef BUS_MATCH_DEFINES_SVH
`define BUS_MATCH_DEFINES_SVH

// ---------------------------------------------
// register map
// ---------------------------------------------
`define CFG_OFS        12'h000
`define STAT_OFS       12'h004
`define MBOX_LO_OFS    12'h008
`define MBOX_HI_OFS    12'h00c

// ---------------------------------------------
// lanes and reset values
// ---------------------------------------------
`define LONG_W         36
`define WORD_W         18
`define BYTE_W         9
`define MBOX_RST       36'h0_0000_0000
`define RDATA_RST      32'h0000_0000

`endif

// ---- include/bus_match_pkg.sv ----
// types for the read-side bus-matching path
// widths and codes written here as literals, not taken from bus_match_defines.svh
`default_nettype none
package bus_match_pkg;

   typedef enum logic [1:0] {
      W_LONG = 2'b00,
      W_WORD = 2'b01,
      W_BYTE = 2'b10
   } width_t;

   // memory read side, first-word-fall-through style
   typedef struct packed {
      logic        valid;
      logic [35:0] data;
   } mem_in_t;

   typedef struct packed {
      logic        mr;
      width_t      width;
      logic        msb;
      logic        cfg_ok;
      logic [35:0] aux;
      logic [35:0] word;
      logic [1:0]  left;
      logic        pop;
      logic        ready;
      logic [35:0] dout;
      logic [35:0] mbox;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } state_t;

endpackage : bus_match_pkg
`default_nettype wire

// ---- sim/mem_model.sv ----
// fall-through memory model feeding the read-side bus-matching path
// assumes pop is sampled at the rising edge of pclk
`default_nettype none
module mem_model (
   input  wire logic                 pclk,
   input  wire logic                 pop,
   output var bus_match_pkg::mem_in_t head
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [35:0] q[$];
   logic [35:0] last;
   // ----------------
   // storage
   // ----------------
   // whole long words
   task automatic push(input logic [35:0] w);
      q.push_back(w);
      show();
   endtask : push
   // an empty head shows the inverted last word, so stale data never passes
   task automatic show();
      head.valid <= (q.size() != 0);
      head.data  <= (q.size() != 0) ? q[0] : ~last;
   endtask : show
   initial begin
      last = 36'h0_0000_0000;
      head = '0;
   end
   always @(posedge pclk) begin
      if (pop && q.size() != 0) begin
         last = q.pop_front();
         show();
      end
   end
endmodule : mem_model
`default_nettype wire

// ---- sim/tb_port_b_bus_matching_read.sv ----
// bench for the read-side bus-matching path
// assumes mem_model on the memory side and an APB master in this module
`default_nettype none
module tb_port_b_bus_matching_read;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        master_reset_n, width_match_select, size_select;
   logic        msb_first_select, read_port_mailbox_select, rd_en;
   logic        mem_pop, empty_output_ready_flag, full_input_ready_flag;
   logic [35:0] dout;
   int          error_cnt, samples_checked;
   bus_match_pkg::mem_in_t mem_in;
   bus_match_read uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .master_reset_n,
      .width_match_select, .size_select, .msb_first_select,
      .read_port_mailbox_select, .rd_en, .mem_in, .mem_pop, .dout,
      .empty_output_ready_flag, .full_input_ready_flag);
   mem_model mem (.pclk, .pop(mem_pop), .head(mem_in));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------
   // tasks
   // ----------------
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // lane k of a long word, k counted from the low end
   function automatic logic [35:0] part(input logic [35:0] w, input int n,
      input logic big, input int i);
      int k;
      k = big ? n - 1 - i : i;
      return (w >> (k * (36 / n))) & ((36'h1 << (36 / n)) - 36'h1);
   endfunction : part
   task automatic setup(input logic wm, input logic sz, input logic mf);
      master_reset_n <= 1'b0;
      // width pins stay put until the next master reset
      width_match_select <= wm;
      size_select <= sz;
      msb_first_select <= mf;
      repeat (2) @(posedge pclk);
      master_reset_n <= 1'b1;
      do @(posedge pclk); while (full_input_ready_flag !== 1'b1);
      // late changes must not disturb the order caught at reset
      msb_first_select <= ~mf;
   endtask : setup
   task automatic rd_port(input logic mb, output logic [35:0] got);
      while (!mb && empty_output_ready_flag !== 1'b1) @(posedge pclk);
      read_port_mailbox_select <= mb;
      rd_en <= 1'b1;
      @(posedge pclk);
      rd_en <= 1'b0;
      read_port_mailbox_select <= 1'b0;
      @(posedge pclk);
      got = dout;
      repeat (3) @(posedge pclk);
   endtask : rd_port
   // ----------------
   // scenarios
   // ----------------
   task automatic t_regs();
      logic [31:0] rd;
      logic        err;
      apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
      chk({4'h0, rd}, 36'h0_0000_0000);
      apb(1'b1, 12'h008, 32'h5A5A_A5A5, rd, err);
      apb(1'b1, 12'h00c, 32'h0000_000B, rd, err);
      apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
      chk({4'h0, rd}, 36'h0_5A5A_A5A5);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF, rd, err);
      chk({35'h0_0000_0000, err}, 36'h0_0000_0001);
      apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
      chk({3'h0, err, rd}, 36'h1_0000_0000);
      $display("test regs done");
   endtask : t_regs
   task automatic run_mode(input logic wm, input logic sz, input logic mf,
      input int n);
      logic [35:0] w[2];
      logic [35:0] got;
      logic [35:0] lanes;
      logic [31:0] rd;
      logic        err;
      logic        rdy;
      logic [1:0]  wc;
      w[0] = 36'h9_A5C3_1E7B;
      w[1] = 36'h6_0F1D_2B84;
      wc = (n == 4) ? 2'b10 : ((n == 2) ? 2'b01 : 2'b00);
      lanes = part(36'hF_FFFF_FFFF, n, 1'b0, 0);
      setup(wm, sz, mf);
      chk({35'h0, full_input_ready_flag}, 36'h0_0000_0001);
      apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
      chk({33'h0, rd[3], rd[1:0]}, {33'h0, 1'b1, wc});
      mem.push(w[0]);
      mem.push(w[1]);
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < n; i++) begin
            rd_port(1'b0, got);
            chk(got, part(w[j], n, mf, i));
            rdy = !(j == 1 && i == n - 1);
            chk({35'h0, empty_output_ready_flag}, {35'h0, rdy});
         end
      end
      rd_port(1'b1, got);
      chk(got, 36'hB_5A5A_A5A5 & lanes);
      $display("test mode %0d done", n);
   endtask : run_mode
   initial begin
      error_cnt = 0;
      samples_checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      master_reset_n = 1'b0;
      width_match_select = 1'b0;
      size_select = 1'b0;
      msb_first_select = 1'b0;
      read_port_mailbox_select = 1'b0;
      rd_en = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      run_mode(1'b0, 1'b0, 1'b1, 1);
      run_mode(1'b1, 1'b0, 1'b1, 2);
      run_mode(1'b1, 1'b0, 1'b0, 2);
      run_mode(1'b1, 1'b1, 1'b1, 4);
      run_mode(1'b1, 1'b1, 1'b0, 4);
      final_report();
   end
   initial begin
      #100000;
      error_cnt++;
      final_report();
   end
endmodule : tb_port_b_bus_matching_read
`default_nettype wire
